// ---- pkg/lsfsm_pkg.sv ----
// Purpose: shared constants and types of the line supervision state machine
// Assumes: one clock, CLOCK at 250 MHz
// Notes: mode words are read as {mode_sel_bit0, mode_sel_bit1, mode_sel_bit2}
package lsfsm_pkg;

    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int LSFSM_HOLD_RING_PERIODS = 128;
    localparam int LSFSM_HOLD_CNT_W = 8;

    // ------------------------------------------------------------
    // register map
    // ------------------------------------------------------------
    localparam logic [3:0] LSFSM_ADDR_STATUS = 4'h0;
    localparam logic [3:0] LSFSM_ADDR_IRQ_STAT = 4'h1;
    localparam logic [3:0] LSFSM_ADDR_IRQ_MASK = 4'h2;
    localparam logic [3:0] LSFSM_ADDR_CTRL = 4'h3;
    localparam logic [7:0] LSFSM_CTRL_RESET = 8'h00;
    localparam logic [7:0] LSFSM_MASK_RESET = 8'h00;

    // ------------------------------------------------------------
    // interrupt bit positions
    // ------------------------------------------------------------
    localparam int LSFSM_EV_OFFHOOK = 0;
    localparam int LSFSM_EV_ONHOOK = 1;
    localparam int LSFSM_EV_TIMEOUT = 2;
    localparam int LSFSM_EV_RINGTRIP = 3;
    localparam int LSFSM_EV_W = 4;

    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        LSFSM_PDOWN = 3'b000,
        LSFSM_HIZ = 3'b001,
        LSFSM_STBY = 3'b010,
        LSFSM_ACTIVE = 3'b011,
        LSFSM_ACT_HOLD = 3'b100,
        LSFSM_RINGING = 3'b101,
        LSFSM_ONHOOK_TX = 3'b110
    } lsfsm_state_type;

    typedef enum logic [1:0] {
        LSFSM_MODE_PDOWN = 2'b00,
        LSFSM_MODE_ACTIVE = 2'b01,
        LSFSM_MODE_RING = 2'b10,
        LSFSM_MODE_OHTX = 2'b11
    } lsfsm_mode_type;

    typedef struct packed {
        logic mode_sel_bit0;
        logic mode_sel_bit1;
        logic mode_sel_bit2;
    } lsfsm_modesel_type;

    typedef struct packed {
        logic hiz_offhook_flag;
        logic offhook_flag;
        logic ring_trip;
    } lsfsm_detect_type;

    // mode decode used by the machine and the status register
    function automatic lsfsm_mode_type lsfsm_decode_mode(input lsfsm_modesel_type m);
        if (m.mode_sel_bit0) begin
            return LSFSM_MODE_ACTIVE;
        end else if (m.mode_sel_bit1) begin
            return LSFSM_MODE_OHTX;
        end else if (m.mode_sel_bit2) begin
            return LSFSM_MODE_RING;
        end
        return LSFSM_MODE_PDOWN;
    endfunction : lsfsm_decode_mode

endpackage : lsfsm_pkg

// ---- src/lsfsm_hold_timer.sv ----
// Purpose: hold interval counter driven by ring clock periods
// Assumes: ring_tick is a one-cycle pulse per ring clock period
// Notes: restart clears the count and the timeout flag
`timescale 1ns/1ps
module lsfsm_hold_timer
    import lsfsm_pkg::*;
#(
    parameter int PERIODS = LSFSM_HOLD_RING_PERIODS
) (
    // clock and reset
    input wire logic clk,
    input wire logic arst_n,
    // control
    input wire logic restart,
    input wire logic run,
    input wire logic ring_tick,
    // result
    output logic hold_timeout_flag
);

    logic [LSFSM_HOLD_CNT_W-1:0] count_q;

    if (PERIODS < 1 || PERIODS > (1 << LSFSM_HOLD_CNT_W) - 1) begin : g_bad_periods
        $error("lsfsm_hold_timer: PERIODS out of range");
    end

    // ------------------------------------------------------------
    // counter: restart wins over counting
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            count_q <= '0;
        end else if (restart) begin
            count_q <= '0;
        end else if (run && ring_tick && !hold_timeout_flag) begin
            count_q <= count_q + 1'b1;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            hold_timeout_flag <= 1'b0;
        end else if (restart) begin
            hold_timeout_flag <= 1'b0;
        end else if (run && ring_tick && count_q == LSFSM_HOLD_CNT_W'(PERIODS - 1)) begin
            hold_timeout_flag <= 1'b1;
        end
    end

endmodule : lsfsm_hold_timer

// ---- src/lsfsm_sync.sv ----
// Purpose: two flip-flop synchroniser for a bundle of pin levels
// Assumes: inputs are asynchronous levels
// Notes: the first stage feeds only the second
`timescale 1ns/1ps
module lsfsm_sync #(
    parameter int WIDTH = 1
) (
    // clock and reset
    input wire logic clk,
    input wire logic arst_n,
    // data
    input wire logic [WIDTH-1:0] din,
    output logic [WIDTH-1:0] dout
);

    logic [WIDTH-1:0] meta_q;

    if (WIDTH < 1) begin : g_bad_width
        $error("lsfsm_sync: WIDTH must be at least 1");
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            meta_q <= '0;
            dout <= '0;
        end else begin
            meta_q <= din;
            dout <= meta_q;
        end
    end

endmodule : lsfsm_sync

// ---- src/lsfsm_top.sv ----
// Purpose: supervisory state machine of a subscriber line interface
// Assumes: mode pins, detector flags, ring clock and reset pin are asynchronous
// Notes: registers give software a status view, interrupts and a forced power-down
`timescale 1ns/1ps
module lsfsm_top
    import lsfsm_pkg::*;
#(
    parameter int HOLD_PERIODS = LSFSM_HOLD_RING_PERIODS
) (
    // clock and reset
    input wire logic CLOCK,
    input wire logic ARST_N,
    input wire logic CHIP_RESET_N,
    // mode select pins
    input wire logic MODE_SEL_BIT0,
    input wire logic MODE_SEL_BIT1,
    input wire logic MODE_SEL_BIT2,
    // analog detector flags and ring clock
    input wire logic HIZ_OFFHOOK_FLAG,
    input wire logic OFFHOOK_FLAG,
    input wire logic RING_TRIP,
    input wire logic RING_CLOCK_IN,
    // line outputs
    output logic DETECT,
    output logic RING_RELAY_DRIVE,
    output logic REVERSE_POLARITY,
    output logic [2:0] LINE_STATE,
    // register port
    input wire logic [3:0] REG_ADDR,
    input wire logic [7:0] REG_WDATA,
    input wire logic REG_WR,
    input wire logic REG_RD,
    output logic [7:0] REG_RDATA,
    // interrupt
    output logic IRQ
);

    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    logic [7:0] pins_raw;
    logic [7:0] pins_s;
    lsfsm_modesel_type modesel;
    lsfsm_detect_type det;
    logic ring_clk_s;
    logic reset_pin_n_s;

    assign pins_raw = {CHIP_RESET_N, RING_CLOCK_IN, HIZ_OFFHOOK_FLAG, OFFHOOK_FLAG, RING_TRIP,
                       MODE_SEL_BIT0, MODE_SEL_BIT1, MODE_SEL_BIT2};

    lsfsm_sync #(
        .WIDTH(8)
    ) u_sync (
        .clk(CLOCK),
        .arst_n(ARST_N),
        .din(pins_raw),
        .dout(pins_s)
    );

    assign reset_pin_n_s = pins_s[7];
    assign ring_clk_s = pins_s[6];
    assign det = lsfsm_detect_type'(pins_s[5:3]);
    assign modesel = lsfsm_modesel_type'(pins_s[2:0]);

    // ------------------------------------------------------------
    // ring clock period ticks
    // ------------------------------------------------------------
    logic ring_clk_q;
    logic ring_tick;

    always_ff @(posedge CLOCK or negedge ARST_N) begin
        if (!ARST_N) begin
            ring_clk_q <= 1'b0;
        end else begin
            ring_clk_q <= ring_clk_s;
        end
    end

    // one tick per ring clock period, on its rising edge
    assign ring_tick = ring_clk_s && !ring_clk_q;

    // ------------------------------------------------------------
    // control register and mode decode
    // ------------------------------------------------------------
    logic [7:0] ctrl_q;
    logic soft_pdown;
    lsfsm_mode_type mode;
    lsfsm_mode_type mode_q;
    logic mode_changed;
    logic hold_reset;

    assign soft_pdown = ctrl_q[0];
    assign mode = lsfsm_decode_mode(modesel);
    assign mode_changed = (mode != mode_q);
    // the reset pin is treated like the soft power-down bit: it parks the machine
    assign hold_reset = !reset_pin_n_s || soft_pdown;

    always_ff @(posedge CLOCK or negedge ARST_N) begin
        if (!ARST_N) begin
            mode_q <= LSFSM_MODE_PDOWN;
        end else begin
            mode_q <= mode;
        end
    end

    // ------------------------------------------------------------
    // state machine
    // ------------------------------------------------------------
    lsfsm_state_type state_q;
    lsfsm_state_type state_d;
    logic hold_timeout_flag;
    logic timer_restart;
    logic timer_run;
    logic trip_latch_q;

    always_comb begin
        state_d = state_q;
        timer_restart = 1'b0;
        if (hold_reset) begin
            state_d = LSFSM_PDOWN;
        end else begin
            case (state_q)
                LSFSM_PDOWN: begin
                    if (mode == LSFSM_MODE_ACTIVE) begin
                        state_d = LSFSM_HIZ;
                    end else if (mode == LSFSM_MODE_RING) begin
                        state_d = LSFSM_RINGING;
                    end else if (mode == LSFSM_MODE_OHTX) begin
                        state_d = LSFSM_ONHOOK_TX;
                    end
                end
                LSFSM_HIZ: begin
                    // feeding looks only at the longitudinal-sensitive flag
                    if (det.hiz_offhook_flag) begin
                        state_d = LSFSM_STBY;
                        timer_restart = 1'b1;
                    end
                end
                LSFSM_STBY: begin
                    if (det.offhook_flag) begin
                        state_d = LSFSM_ACTIVE;
                    end else if (hold_timeout_flag) begin
                        state_d = LSFSM_HIZ;
                    end
                end
                LSFSM_ACTIVE: begin
                    if (!det.offhook_flag && !trip_latch_q) begin
                        state_d = LSFSM_ACT_HOLD;
                        timer_restart = 1'b1;
                    end
                end
                LSFSM_ACT_HOLD: begin
                    if (det.offhook_flag) begin
                        state_d = LSFSM_ACTIVE;
                    end else if (hold_timeout_flag) begin
                        state_d = LSFSM_HIZ;
                    end
                end
                LSFSM_RINGING: begin
                    if (det.ring_trip) begin
                        state_d = LSFSM_ACTIVE;
                    end
                end
                LSFSM_ONHOOK_TX: begin
                    if (det.offhook_flag) begin
                        state_d = LSFSM_ACTIVE;
                    end
                end
                default: begin
                    state_d = LSFSM_PDOWN;
                end
            endcase
            // a change of decoded mode restarts supervision from its entry state; active mode keeps a line already in ACTIVE
            if (mode_changed) begin
                case (mode)
                    LSFSM_MODE_ACTIVE: state_d = (state_q == LSFSM_ACTIVE) ? LSFSM_ACTIVE : LSFSM_HIZ;
                    LSFSM_MODE_RING: state_d = LSFSM_RINGING;
                    LSFSM_MODE_OHTX: state_d = LSFSM_ONHOOK_TX;
                    default: state_d = LSFSM_PDOWN;
                endcase
            end
        end
    end

    always_ff @(posedge CLOCK or negedge ARST_N) begin
        if (!ARST_N) begin
            state_q <= LSFSM_PDOWN;
        end else begin
            state_q <= state_d;
        end
    end

    assign timer_run = (state_q == LSFSM_STBY) || (state_q == LSFSM_ACT_HOLD);

    lsfsm_hold_timer #(
        .PERIODS(HOLD_PERIODS)
    ) u_hold (
        .clk(CLOCK),
        .arst_n(ARST_N),
        .restart(timer_restart),
        .run(timer_run),
        .ring_tick(ring_tick),
        .hold_timeout_flag(hold_timeout_flag)
    );

    // ------------------------------------------------------------
    // ring trip latch, relay and polarity
    // ------------------------------------------------------------
    logic trip_event;
    logic relay_q;
    logic polarity_q;

    assign trip_event = (state_q == LSFSM_RINGING) && det.ring_trip && !hold_reset;

    // latched trip survives loop opening until the decoded mode changes or the machine is parked
    always_ff @(posedge CLOCK or negedge ARST_N) begin
        if (!ARST_N) begin
            trip_latch_q <= 1'b0;
        end else if (trip_event) begin
            trip_latch_q <= 1'b1;
        end else if (mode_changed || hold_reset) begin
            trip_latch_q <= 1'b0;
        end
    end

    // after a trip the relay opens only in a low phase of the ring clock to avoid arcing; leaving ringing without a trip opens it at once
    always_ff @(posedge CLOCK or negedge ARST_N) begin
        if (!ARST_N) begin
            relay_q <= 1'b0;
        end else if (!trip_latch_q && state_d != LSFSM_RINGING && state_q != LSFSM_RINGING) begin
            relay_q <= 1'b0;
        end else if (state_q == LSFSM_RINGING && !trip_latch_q && !trip_event) begin
            relay_q <= 1'b1;
        end else if ((trip_latch_q || trip_event) && !ring_clk_s) begin
            relay_q <= 1'b0;
        end
    end

    // polarity sampled from the third bit outside ringing, frozen during it and while a trip is latched
    always_ff @(posedge CLOCK or negedge ARST_N) begin
        if (!ARST_N) begin
            polarity_q <= 1'b0;
        end else if (mode != LSFSM_MODE_RING && state_q != LSFSM_RINGING && !trip_latch_q) begin
            polarity_q <= modesel.mode_sel_bit2;
        end
    end

    // ------------------------------------------------------------
    // line outputs
    // ------------------------------------------------------------
    always_ff @(posedge CLOCK or negedge ARST_N) begin
        if (!ARST_N) begin
            DETECT <= 1'b1;
            RING_RELAY_DRIVE <= 1'b0;
            REVERSE_POLARITY <= 1'b0;
            LINE_STATE <= LSFSM_PDOWN;
        end else begin
            // low reports off-hook; the hold state already shows on-hook
            DETECT <= !((state_d == LSFSM_ACTIVE) || trip_latch_q || trip_event);
            RING_RELAY_DRIVE <= relay_q;
            REVERSE_POLARITY <= polarity_q;
            LINE_STATE <= state_d;
        end
    end

    // ------------------------------------------------------------
    // interrupts
    // ------------------------------------------------------------
    logic [LSFSM_EV_W-1:0] events;
    logic [LSFSM_EV_W-1:0] irq_stat_q;
    logic [LSFSM_EV_W-1:0] irq_mask_q;
    logic timeout_q;
    logic w_stat;

    always_ff @(posedge CLOCK or negedge ARST_N) begin
        if (!ARST_N) begin
            timeout_q <= 1'b0;
        end else begin
            timeout_q <= hold_timeout_flag;
        end
    end

    always_comb begin
        events = '0;
        events[LSFSM_EV_OFFHOOK] = (state_d == LSFSM_ACTIVE) && (state_q != LSFSM_ACTIVE);
        events[LSFSM_EV_ONHOOK] = (state_d == LSFSM_ACT_HOLD) && (state_q == LSFSM_ACTIVE);
        events[LSFSM_EV_TIMEOUT] = hold_timeout_flag && !timeout_q;
        events[LSFSM_EV_RINGTRIP] = trip_event && !trip_latch_q;
    end

    assign w_stat = REG_WR && (REG_ADDR == LSFSM_ADDR_IRQ_STAT);

    // a new event wins over a write-one clear in the same cycle
    always_ff @(posedge CLOCK or negedge ARST_N) begin
        if (!ARST_N) begin
            irq_stat_q <= '0;
        end else begin
            irq_stat_q <= (irq_stat_q & ~(w_stat ? REG_WDATA[LSFSM_EV_W-1:0] : '0)) | events;
        end
    end

    always_ff @(posedge CLOCK or negedge ARST_N) begin
        if (!ARST_N) begin
            irq_mask_q <= LSFSM_MASK_RESET[LSFSM_EV_W-1:0];
        end else if (REG_WR && REG_ADDR == LSFSM_ADDR_IRQ_MASK) begin
            irq_mask_q <= REG_WDATA[LSFSM_EV_W-1:0];
        end
    end

    assign IRQ = |(irq_stat_q & irq_mask_q);

    // ------------------------------------------------------------
    // register port
    // ------------------------------------------------------------
    always_ff @(posedge CLOCK or negedge ARST_N) begin
        if (!ARST_N) begin
            ctrl_q <= LSFSM_CTRL_RESET;
        end else if (REG_WR && REG_ADDR == LSFSM_ADDR_CTRL) begin
            ctrl_q <= {7'h00, REG_WDATA[0]};
        end
    end

    always_ff @(posedge CLOCK or negedge ARST_N) begin
        if (!ARST_N) begin
            REG_RDATA <= 8'h00;
        end else if (REG_RD) begin
            case (REG_ADDR)
                LSFSM_ADDR_STATUS: REG_RDATA <= {trip_latch_q, hold_timeout_flag, mode_q, 1'b0, state_q};
                LSFSM_ADDR_IRQ_STAT: REG_RDATA <= {4'h0, irq_stat_q};
                LSFSM_ADDR_IRQ_MASK: REG_RDATA <= {4'h0, irq_mask_q};
                LSFSM_ADDR_CTRL: REG_RDATA <= ctrl_q;
                default: REG_RDATA <= 8'h00;
            endcase
        end else begin
            REG_RDATA <= 8'h00;
        end
    end

endmodule : lsfsm_top

// ---- testbench/lsfsm_ctrl_model.sv ----
// Purpose: line card controller that drives the mode pins
// Assumes: detect low while ringing means a ring trip
// Notes: answers a trip after RESP cycles, as slow software would
`timescale 1ns/1ps
module lsfsm_ctrl_model
    import lsfsm_pkg::*;
#(
    parameter int RESP = 24
) (
    // clock
    input wire logic clk,
    // request and line status
    input wire lsfsm_modesel_type req,
    input wire logic detect,
    output lsfsm_modesel_type mode
);
    // ----------------------------------------
    // mode word
    // ----------------------------------------
    lsfsm_modesel_type req_q = 3'h0;
    int cnt = 0;
    initial mode = 3'h0;
    always @(posedge clk) begin
        req_q <= req;
        if (req != req_q) begin
            mode <= req;
            cnt <= 0;
        end else if (mode == 3'h1 && detect === 1'b0) begin
            cnt <= cnt + 1;
            if (cnt == RESP) begin
                mode <= 3'h4;
            end
        end
    end
endmodule : lsfsm_ctrl_model

// ---- testbench/lsfsm_sva.sv ----
// Purpose: port level checks of the line supervision machine
// Assumes: ring clock held for 8 cycles per phase, small hold count
// Notes: watches the ports of lsfsm_top only
`timescale 1ns/1ps
module lsfsm_sva
    import lsfsm_pkg::*;
#(
    parameter int HOLD_PERIODS = LSFSM_HOLD_RING_PERIODS
) (
    // clock and reset
    input wire logic CLOCK,
    input wire logic ARST_N,
    input wire logic CHIP_RESET_N,
    // detector side
    input wire logic HIZ_OFFHOOK_FLAG,
    input wire logic OFFHOOK_FLAG,
    input wire logic RING_TRIP,
    input wire logic RING_CLOCK_IN,
    // line outputs
    input wire logic DETECT,
    input wire logic RING_RELAY_DRIVE,
    input wire logic [2:0] LINE_STATE
);
    // ----------------------------------------
    // properties
    // ----------------------------------------
    localparam int HMAX = 400;
    default clocking @(posedge CLOCK); endclocking
    default disable iff (!ARST_N);
    // pin sync adds up to four cycles, so flags are looked at over that span
    chk_pin_pdown: assert property ($fell(CHIP_RESET_N) |-> ##[1:6] LINE_STATE == 3'h0)
        else $error("reset pin did not power down");
    chk_feed_exit: assert property (LINE_STATE == 3'h1 ##1 LINE_STATE == 3'h2 |->
        $past(HIZ_OFFHOOK_FLAG, 2) || $past(HIZ_OFFHOOK_FLAG, 3) || $past(HIZ_OFFHOOK_FLAG, 4))
        else $error("feeding left without its off-hook flag");
    chk_stby_back: assert property (LINE_STATE == 3'h2 ##1 LINE_STATE == 3'h1 |-> !$past(OFFHOOK_FLAG, 3))
        else $error("stand-by returned to feeding while off-hook");
    chk_stby_bound: assert property ($rose(LINE_STATE == 3'h2) |-> ##[1:HMAX] LINE_STATE != 3'h2)
        else $error("stand-by never ended");
    chk_hold_bound: assert property ($rose(LINE_STATE == 3'h4) |-> ##[1:HMAX] LINE_STATE != 3'h4)
        else $error("active hold never ended");
    chk_active_low: assert property (LINE_STATE == 3'h3 [*3] |-> !DETECT)
        else $error("detect high in active");
    chk_hold_high: assert property (LINE_STATE == 3'h4 [*3] |-> DETECT)
        else $error("detect low in active hold");
    chk_trip_active: assert property ((LINE_STATE == 3'h5 && RING_TRIP) [*2] |->
        ##[0:4] (LINE_STATE == 3'h3 && !DETECT))
        else $error("ring trip did not force active");
    chk_relay_sync: assert property ($fell(RING_RELAY_DRIVE) |->
        !($past(RING_CLOCK_IN, 2) && $past(RING_CLOCK_IN, 3) && $past(RING_CLOCK_IN, 4)))
        else $error("relay released while ring clock high");
    chk_trip_latch: assert property (LINE_STATE == 3'h5 ##1 LINE_STATE == 3'h3 |-> ##2 !DETECT [*6])
        else $error("ring trip detect not held");
    cov_trip: cover property (LINE_STATE == 3'h5 ##1 LINE_STATE == 3'h3);
    cov_stby_to: cover property (LINE_STATE == 3'h2 ##1 LINE_STATE == 3'h1);
    cov_hold_back: cover property (LINE_STATE == 3'h4 ##1 LINE_STATE == 3'h3);
endmodule : lsfsm_sva

bind lsfsm_top lsfsm_sva #(.HOLD_PERIODS(HOLD_PERIODS)) lsfsm_sva_inst (
    .CLOCK(CLOCK),
    .ARST_N(ARST_N),
    .CHIP_RESET_N(CHIP_RESET_N),
    .HIZ_OFFHOOK_FLAG(HIZ_OFFHOOK_FLAG),
    .OFFHOOK_FLAG(OFFHOOK_FLAG),
    .RING_TRIP(RING_TRIP),
    .RING_CLOCK_IN(RING_CLOCK_IN),
    .DETECT(DETECT),
    .RING_RELAY_DRIVE(RING_RELAY_DRIVE),
    .LINE_STATE(LINE_STATE)
);

// ---- testbench/test_lsfsm_top.sv ----
// Purpose: self checking bench of the line supervision machine
// Assumes: hold of 4 ring periods, ring clock period of 16 cycles
// Notes: state changes and read data are checked against queued notes
`timescale 1ns/1ps
module test_lsfsm_top;
    import lsfsm_pkg::*;
    // ----------------------------------------
    // stimulus and checking
    // ----------------------------------------
    logic CLOCK = 1'b0, ARST_N = 1'b0, CHIP_RESET_N = 1'b1, RING_CLOCK_IN = 1'b0;
    logic HIZ_OFFHOOK_FLAG = 1'b0, OFFHOOK_FLAG = 1'b0, RING_TRIP = 1'b0;
    logic REG_WR = 1'b0, REG_RD = 1'b0, rd_q = 1'b0;
    logic [3:0] REG_ADDR = 4'h0;
    logic [7:0] REG_WDATA = 8'h00, REG_RDATA;
    logic DETECT, RING_RELAY_DRIVE, REVERSE_POLARITY, IRQ;
    logic [2:0] LINE_STATE, st_q = 3'h0;
    logic [15:0] rv;
    lsfsm_modesel_type req = 3'h0, mode;
    logic [7:0] st_exp[$];
    logic [15:0] rd_exp[$];
    int n_errors = 0, num_checks = 0, seed = 82, cyc;

    lsfsm_top #(.HOLD_PERIODS(4)) lsfsm_top_inst (.CLOCK(CLOCK), .ARST_N(ARST_N), .CHIP_RESET_N(CHIP_RESET_N),
        .MODE_SEL_BIT0(mode.mode_sel_bit0), .MODE_SEL_BIT1(mode.mode_sel_bit1), .MODE_SEL_BIT2(mode.mode_sel_bit2),
        .HIZ_OFFHOOK_FLAG(HIZ_OFFHOOK_FLAG), .OFFHOOK_FLAG(OFFHOOK_FLAG), .RING_TRIP(RING_TRIP),
        .RING_CLOCK_IN(RING_CLOCK_IN), .DETECT(DETECT), .RING_RELAY_DRIVE(RING_RELAY_DRIVE),
        .REVERSE_POLARITY(REVERSE_POLARITY), .LINE_STATE(LINE_STATE), .REG_ADDR(REG_ADDR),
        .REG_WDATA(REG_WDATA), .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA), .IRQ(IRQ));
    lsfsm_ctrl_model lsfsm_ctrl_model_inst (.clk(CLOCK), .req(req), .detect(DETECT), .mode(mode));

    always #2 CLOCK = ~CLOCK;
    always begin
        repeat (8) @(posedge CLOCK);
        RING_CLOCK_IN <= ~RING_CLOCK_IN;
    end

    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        num_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check

    task automatic stop_test();
        $display("checks=%0d mismatches=%0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : stop_test

    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge CLOCK);
        REG_WR <= 1'b1;
        REG_ADDR <= a;
        REG_WDATA <= d;
        @(posedge CLOCK);
        REG_WR <= 1'b0;
    endtask : wr

    // mask m keeps only the bits whose value is fixed at that moment
    task automatic rd(input logic [3:0] a, input logic [7:0] e, input logic [7:0] m);
        @(posedge CLOCK);
        rd_exp.push_back({m, e});
        REG_RD <= 1'b1;
        REG_ADDR <= a;
        @(posedge CLOCK);
        REG_RD <= 1'b0;
    endtask : rd

    task automatic wst(input logic [2:0] s);
        cyc = 0;
        while (LINE_STATE !== s && cyc < 600) begin
            @(posedge CLOCK);
            cyc++;
        end
        if (cyc == 600) begin
            check(LINE_STATE, s);
        end
    endtask : wst

    task automatic go(input logic [2:0] a, input logic [2:0] b);
        st_exp.push_back(a);
        if (b != a) begin
            st_exp.push_back(b);
        end
    endtask : go

    always @(posedge CLOCK) begin
        if (ARST_N && LINE_STATE !== st_q) begin
            check(LINE_STATE, st_exp.size() > 0 ? st_exp.pop_front() : 8'hFF);
        end
        if (rd_q) begin
            rv = rd_exp.size() > 0 ? rd_exp.pop_front() : 16'h00FF;
            check(REG_RDATA & rv[15:8], rv[7:0]);
        end
        st_q <= LINE_STATE;
        rd_q <= REG_RD;
    end

    initial begin
        repeat (20000) @(posedge CLOCK);
        n_errors++;
        $display("[FAIL] t=%0t watchdog ran out", $time);
        stop_test();
    end

    initial begin
        repeat (12) @(posedge CLOCK);
        ARST_N <= 1'b1;
        rd(LSFSM_ADDR_IRQ_MASK, LSFSM_MASK_RESET, 8'hFF);
        rd(LSFSM_ADDR_CTRL, LSFSM_CTRL_RESET, 8'hFF);
        wr(4'hF, 8'($random(seed)));
        rd(4'hF, 8'h00, 8'hFF);
        $display("test registers done");
        go(3'h1, 3'h1);
        req <= 3'h5;
        wst(3'h1);
        rd(LSFSM_ADDR_STATUS, 8'h11, 8'h37);
        go(3'h2, 3'h3);
        HIZ_OFFHOOK_FLAG <= 1'b1;
        OFFHOOK_FLAG <= 1'b1;
        wst(3'h3);
        HIZ_OFFHOOK_FLAG <= 1'b0;
        repeat (4) @(posedge CLOCK);
        check(DETECT, 1'b0);
        go(3'h4, 3'h3);
        OFFHOOK_FLAG <= 1'b0;
        wst(3'h4);
        repeat (8 + ($random(seed) & 15)) @(posedge CLOCK);
        OFFHOOK_FLAG <= 1'b1;
        wst(3'h3);
        go(3'h4, 3'h1);
        OFFHOOK_FLAG <= 1'b0;
        wst(3'h4);
        wst(3'h1);
        check(cyc >= 48, 1'b1);
        $display("test active hold done");
        go(3'h2, 3'h1);
        HIZ_OFFHOOK_FLAG <= 1'b1;
        wst(3'h2);
        HIZ_OFFHOOK_FLAG <= 1'b0;
        wst(3'h1);
        check(cyc >= 48, 1'b1);
        go(3'h2, 3'h3);
        HIZ_OFFHOOK_FLAG <= 1'b1;
        wst(3'h2);
        HIZ_OFFHOOK_FLAG <= 1'b0;
        repeat (20) @(posedge CLOCK);
        OFFHOOK_FLAG <= 1'b1;
        wst(3'h3);
        check(cyc < 8, 1'b1);
        $display("test stand-by done");
        go(3'h0, 3'h1);
        wr(LSFSM_ADDR_CTRL, 8'h01);
        wst(3'h0);
        wr(LSFSM_ADDR_CTRL, 8'h00);
        wst(3'h1);
        go(3'h0, 3'h1);
        CHIP_RESET_N <= 1'b0;
        wst(3'h0);
        CHIP_RESET_N <= 1'b1;
        wst(3'h1);
        $display("test power-down done");
        go(3'h5, 3'h3);
        req <= 3'h1;
        wst(3'h5);
        repeat (30 + ($random(seed) & 15)) @(posedge CLOCK);
        check(RING_RELAY_DRIVE, 1'b1);
        RING_TRIP <= 1'b1;
        wst(3'h3);
        go(3'h4, 3'h4);
        repeat (4) @(posedge CLOCK);
        RING_TRIP <= 1'b0;
        OFFHOOK_FLAG <= 1'b0;
        check(DETECT, 1'b0);
        repeat (8) @(posedge CLOCK);
        check(DETECT, 1'b0);
        check(REVERSE_POLARITY, 1'b1);
        repeat (30) @(posedge CLOCK);
        check(RING_RELAY_DRIVE, 1'b0);
        check(mode, 3'h4);
        check(DETECT, 1'b1);
        check(REVERSE_POLARITY, 1'b0);
        $display("test ringing done");
        rd(LSFSM_ADDR_IRQ_STAT, 8'h0F, 8'hFF);
        wr(LSFSM_ADDR_IRQ_MASK, 8'h00);
        @(negedge CLOCK);
        check(IRQ, 1'b0);
        wr(LSFSM_ADDR_IRQ_MASK, 8'h0F);
        @(negedge CLOCK);
        check(IRQ, 1'b1);
        wr(LSFSM_ADDR_IRQ_STAT, 8'h0F);
        rd(LSFSM_ADDR_IRQ_STAT, 8'h00, 8'hFF);
        check(IRQ, 1'b0);
        $display("test interrupts done");
        go(3'h0, 3'h0);
        req <= 3'h0;
        OFFHOOK_FLAG <= 1'b0;
        wst(3'h0);
        go(3'h6, 3'h3);
        req <= 3'h3;
        wst(3'h6);
        OFFHOOK_FLAG <= 1'b1;
        wst(3'h3);
        repeat (4) @(posedge CLOCK);
        $display("test on-hook transmission done");
        stop_test();
    end
endmodule : test_lsfsm_top
